// *** verilog/csbu_unit.sv ***
`timescale 1ns/1ps
module csbu_unit (
	input  wire logic                   clock,
	input  wire logic                   resetn,
	input  wire logic                   issue,
	input  wire csbu_pkg::csbu_op_t     op,
	input  wire logic [7:0]             reg_operand,
	input  wire logic [7:0]             immediate,
	input  wire logic [7:0]             io_operand,
	input  wire logic [2:0]             bit_select,
	input  wire logic [6:0]             offset,
	input  wire logic                   next_is_long,
	output logic                        busy,
	output logic                        done,
	output logic [11:0]                 pc,
	output logic [7:0]                  status_flags
);
	// ****************************************************************
	// Internal signals.
	// ****************************************************************
	csbu_pkg::csbu_state_t state;
	csbu_pkg::csbu_state_t next_state;
	logic [1:0]            wait_count;
	logic [1:0]            next_wait_count;
	logic [1:0]            next_wait;
	logic [7:0]            compare_flags;
	logic [11:0]           next_pc;
	logic [11:0]           seq_pc;
	logic [11:0]           skip_pc;
	logic [11:0]           branch_pc;
	logic [11:0]           offset_ext;
	logic                  accept;
	logic                  is_compare;
	logic                  is_skip_reg;
	logic                  is_skip_io;
	logic                  is_branch_set;
	logic                  is_branch_clear;
	logic                  is_branch_ne;
	logic                  reg_bit;
	logic                  io_bit;
	logic                  flag_bit;
	logic                  zero_flag;
	logic                  take_skip;
	logic                  take_branch;
	logic                  next_done;

	csbu_compare u_compare (
		.operand   (reg_operand),
		.constant  (immediate),
		.flags_in  (status_flags),
		.flags_out (compare_flags)
	);

	// ****************************************************************
	// Operation decode.
	// ****************************************************************
	always_comb begin
		is_compare      = 1'b0;
		is_skip_reg     = 1'b0;
		is_skip_io      = 1'b0;
		is_branch_set   = 1'b0;
		is_branch_clear = 1'b0;
		is_branch_ne    = 1'b0;
		case (op)
			csbu_pkg::CSBU_OP_COMPARE_IMMEDIATE: begin
				is_compare = 1'b1;
			end
			csbu_pkg::CSBU_OP_SKIP_REG_BIT_CLEAR: begin
				is_skip_reg = 1'b1;
			end
			csbu_pkg::CSBU_OP_SKIP_IO_BIT_SET: begin
				is_skip_io = 1'b1;
			end
			csbu_pkg::CSBU_OP_BRANCH_FLAG_SET: begin
				is_branch_set = 1'b1;
			end
			csbu_pkg::CSBU_OP_BRANCH_FLAG_CLEAR: begin
				is_branch_clear = 1'b1;
			end
			csbu_pkg::CSBU_OP_BRANCH_NOT_EQUAL: begin
				is_branch_ne = 1'b1;
			end
			default: begin
				is_compare = 1'b0;
			end
		endcase
	end

	assign accept = issue & ~busy;

	// ****************************************************************
	// Condition tests.
	// ****************************************************************
	assign reg_bit   = reg_operand[bit_select];
	assign io_bit    = io_operand[bit_select];
	assign flag_bit  = status_flags[bit_select];
	assign zero_flag = status_flags[csbu_pkg::FLAG_Z];

	always_comb begin
		take_skip   = 1'b0;
		take_branch = 1'b0;
		if (is_skip_reg) begin
			take_skip = ~reg_bit; // RULE2
		end
		if (is_skip_io) begin
			take_skip = io_bit; // RULE3
		end
		if (is_branch_set) begin
			take_branch = flag_bit; // RULE4
		end
		if (is_branch_clear) begin
			take_branch = ~flag_bit; // RULE5
		end
		if (is_branch_ne) begin
			take_branch = ~zero_flag; // RULE6
		end
	end

	// ****************************************************************
	// Target computation.
	// ****************************************************************
	assign offset_ext = {{(csbu_pkg::PC_W - csbu_pkg::OFS_W){offset[6]}}, offset}; // RULE7
	assign seq_pc     = pc + csbu_pkg::PC_STEP;
	assign skip_pc    = pc + (next_is_long ? csbu_pkg::SKIP_TWO : csbu_pkg::SKIP_ONE); // RULE2
	assign branch_pc  = pc + offset_ext + csbu_pkg::PC_STEP; // RULE4 RULE5 RULE6

	always_comb begin
		next_pc = seq_pc;
		if (take_skip) begin
			next_pc = skip_pc; // RULE2 RULE3
		end else if (take_branch) begin
			next_pc = branch_pc; // RULE4 RULE5 RULE6
		end
	end

	// ****************************************************************
	// Extra cycles of a taken skip or branch.
	// ****************************************************************
	always_comb begin
		next_wait = csbu_pkg::WAIT_NONE;
		if (take_skip) begin
			next_wait = next_is_long ? csbu_pkg::WAIT_TWO : csbu_pkg::WAIT_ONE; // RULE3
		end else if (take_branch) begin
			next_wait = csbu_pkg::WAIT_ONE; // RULE4
		end
	end

	// ****************************************************************
	// Cycle sequencing.
	// ****************************************************************
	assign busy = (state == csbu_pkg::CSBU_ST_WAIT);

	always_comb begin
		next_state      = state;
		next_wait_count = wait_count;
		next_done       = 1'b0;
		case (state)
			csbu_pkg::CSBU_ST_IDLE: begin
				if (accept) begin
					if (next_wait == csbu_pkg::WAIT_NONE) begin
						next_done = 1'b1;
					end else begin
						next_wait_count = next_wait - csbu_pkg::WAIT_ONE;
						next_state      = csbu_pkg::CSBU_ST_WAIT; // RULE3
					end
				end
			end
			csbu_pkg::CSBU_ST_WAIT: begin
				if (wait_count == csbu_pkg::WAIT_NONE) begin
					next_state = csbu_pkg::CSBU_ST_IDLE;
					next_done  = 1'b1;
				end else begin
					next_wait_count = wait_count - csbu_pkg::WAIT_ONE;
				end
			end
			default: begin
				next_state = csbu_pkg::CSBU_ST_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// Sequencer state.
	// ****************************************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= csbu_pkg::CSBU_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// Remaining extra cycles.
	// ****************************************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wait_count <= csbu_pkg::WAIT_NONE;
		end else begin
			wait_count <= next_wait_count;
		end
	end

	// ****************************************************************
	// Completion pulse.
	// ****************************************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			done <= 1'b0;
		end else begin
			done <= next_done;
		end
	end

	// ****************************************************************
	// Program counter.
	// ****************************************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pc <= csbu_pkg::PC_RESET;
		end else if (accept) begin
			pc <= next_pc;
		end
	end

	// ****************************************************************
	// Status flags: only compare-immediate changes them.
	// ****************************************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			status_flags <= csbu_pkg::FLAGS_RESET;
		end else if (accept && is_compare) begin
			status_flags <= compare_flags; // RULE1
		end
	end
endmodule // csbu_unit

// *** verilog/csbu_pkg.sv ***
// Function
// RULE1: Compare-immediate subtracts constant, discards difference, updates Z N V C H only. The code also updates S.
// RULE2: Skip-if-register-bit-clear bypasses next instruction by advancing PC 2 or 3.
// RULE3: Skip-if-I/O-bit-set bypasses next instruction, taking one, two or three cycles.
// RULE4: Branch-if-flag-set loads PC plus offset plus one; one cycle, two taken.
// RULE5: Branch-if-flag-clear adds offset plus one when selected flag is zero.
// RULE6: Branch-if-not-equal branches only when zero flag clear, flags unchanged.
// RULE7: Relative branch offset is a signed two's-complement value.
package csbu_pkg;

	// ****************************************************************
	// Widths, flag positions and reset values.
	// ****************************************************************
	localparam int          PC_W       = 12;
	localparam int          OFS_W      = 7;
	localparam int          FLAG_C     = 0;
	localparam int          FLAG_Z     = 1;
	localparam int          FLAG_N     = 2;
	localparam int          FLAG_V     = 3;
	localparam int          FLAG_S     = 4;
	localparam int          FLAG_H     = 5;
	localparam logic [11:0] PC_RESET   = 12'h000;
	localparam logic [7:0]  FLAGS_RESET = 8'h00;
	localparam logic [11:0] PC_STEP    = 12'h001;
	localparam logic [11:0] SKIP_ONE   = 12'h002;
	localparam logic [11:0] SKIP_TWO   = 12'h003;
	localparam logic [1:0]  WAIT_NONE  = 2'h0;
	localparam logic [1:0]  WAIT_ONE   = 2'h1;
	localparam logic [1:0]  WAIT_TWO   = 2'h2;

	// ****************************************************************
	// Operation selects.
	// ****************************************************************
	typedef enum logic [2:0] {
		CSBU_OP_NONE              = 3'b000,
		CSBU_OP_COMPARE_IMMEDIATE = 3'b001,
		CSBU_OP_SKIP_REG_BIT_CLEAR = 3'b010,
		CSBU_OP_SKIP_IO_BIT_SET   = 3'b011,
		CSBU_OP_BRANCH_FLAG_SET   = 3'b100,
		CSBU_OP_BRANCH_FLAG_CLEAR = 3'b101,
		CSBU_OP_BRANCH_NOT_EQUAL  = 3'b110
	} csbu_op_t;

	typedef enum logic [1:0] {
		CSBU_ST_IDLE = 2'b00,
		CSBU_ST_WAIT = 2'b01
	} csbu_state_t;

endpackage

// *** verilog/csbu_compare.sv ***
`timescale 1ns/1ps
module csbu_compare (
	input  wire logic [7:0] operand,
	input  wire logic [7:0] constant,
	input  wire logic [7:0] flags_in,
	output logic      [7:0] flags_out
);
	logic [7:0] diff;

	// ****************************************************************
	// Subtract without write-back; Z N V C H and S derived.
	// ****************************************************************
	always_comb begin
		diff      = operand - constant; // RULE1
		flags_out = flags_in;
		flags_out[csbu_pkg::FLAG_Z] = (diff == 8'h00);
		flags_out[csbu_pkg::FLAG_N] = diff[7];
		flags_out[csbu_pkg::FLAG_V] = (operand[7] & ~constant[7] & ~diff[7])
			| (~operand[7] & constant[7] & diff[7]);
		flags_out[csbu_pkg::FLAG_C] = (~operand[7] & constant[7]) | (constant[7] & diff[7])
			| (diff[7] & ~operand[7]);
		flags_out[csbu_pkg::FLAG_H] = (~operand[3] & constant[3]) | (constant[3] & diff[3])
			| (diff[3] & ~operand[3]);
		flags_out[csbu_pkg::FLAG_S] = flags_out[csbu_pkg::FLAG_N] ^ flags_out[csbu_pkg::FLAG_V];
	end
endmodule // csbu_compare

// *** bench/csbu_unit_checker.sv ***
`timescale 1ns/1ps
module csbu_unit_checker (
	input wire logic               clock,
	input wire logic               resetn,
	input wire logic               issue,
	input wire logic               next_is_long,
	input wire logic               busy,
	input wire logic               done,
	input wire csbu_pkg::csbu_op_t op,
	input wire logic [7:0]         reg_operand,
	input wire logic [7:0]         immediate,
	input wire logic [7:0]         io_operand,
	input wire logic [7:0]         status_flags,
	input wire logic [2:0]         bit_select,
	input wire logic [6:0]         offset,
	input wire logic [11:0]        pc
);
	wire        t  = issue & ~busy;
	wire [7:0]  d  = reg_operand - immediate;
	wire [11:0] br = pc + {{5{offset[6]}}, offset} + 12'h001;
	wire [11:0] sk = pc + (next_is_long ? 12'h003 : 12'h002);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_CMP: assert property (t && op == 3'h1 |=> pc == $past(pc) + 12'h001 &&
		status_flags[2:0] == $past({d[7], d == 8'h00, reg_operand < immediate})) else $error("cmp");
	AST_SRC: assert property (t && op == 3'h2 && !reg_operand[bit_select] |=>
		pc == $past(sk) && busy) else $error("reg skip");
	AST_SIS: assert property (t && op == 3'h3 && io_operand[bit_select] && next_is_long |=>
		pc == $past(sk) && busy ##1 busy ##1 done && !busy) else $error("io skip");
	AST_SSH: assert property (t && op == 3'h3 && io_operand[bit_select] && !next_is_long |=>
		pc == $past(sk) && busy ##1 done && !busy) else $error("io short skip");
	AST_SKU: assert property (t && ((op == 3'h2 && reg_operand[bit_select])
		|| (op == 3'h3 && !io_operand[bit_select])) |=> pc == $past(pc) + 12'h001 && done
		&& !busy) else $error("skip untaken");
	AST_FLG: assert property (!(t && op == 3'h1) |=> $stable(status_flags))
		else $error("flags changed");
	AST_BFS: assert property (t && op == 3'h4 && status_flags[bit_select] |=>
		pc == $past(br) && busy ##1 done) else $error("set branch");
	AST_BNT: assert property (t && op == 3'h4 && !status_flags[bit_select] |=>
		pc == $past(pc) + 12'h001 && done) else $error("set untaken");
	AST_BFC: assert property (t && op == 3'h5 && !status_flags[bit_select] |=>
		pc == $past(br)) else $error("clear branch");
	AST_BNE: assert property (t && op == 3'h6 |=> status_flags == $past(status_flags) &&
		pc == $past(status_flags[1] ? pc + 12'h001 : br)) else $error("ne branch");
	cover property (t && op == 3'h3);
	cover property (t && op == 3'h6);
	cover property (issue && busy);
endmodule // csbu_unit_checker
bind csbu_unit csbu_unit_checker chk (.clock, .resetn, .issue, .next_is_long, .busy, .done, .op,
	.reg_operand, .immediate, .io_operand, .status_flags, .bit_select, .offset, .pc);

// *** bench/csbu_unit_tb.sv ***
`timescale 1ns/1ps
module csbu_unit_tb;
	logic clock = 0, resetn = 0, issue = 0, next_is_long = 0, busy, done;
	csbu_pkg::csbu_op_t op = csbu_pkg::CSBU_OP_NONE;
	logic [7:0] reg_operand = 8'h00, immediate = 8'h00, io_operand = 8'h00, status_flags;
	logic [2:0] bit_select = 3'h0;
	logic [6:0] offset = 7'h00;
	logic [11:0] pc, e = 12'h000;
	int mismatches = 0, n_tests = 0;
	csbu_unit DUT (.clock, .resetn, .issue, .op, .reg_operand, .immediate, .io_operand,
		.bit_select, .offset, .next_is_long, .busy, .done, .pc, .status_flags);
	initial forever #20 clock = ~clock;
	task chk(string nm, logic [11:0] x, logic [11:0] g);
		n_tests++;
		if (g !== x) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask
	task close_out;
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task run(int o, r, i, b, k, l, dx, c);
		int n;
		@(negedge clock);
		op = csbu_pkg::csbu_op_t'(o[2:0]);
		{reg_operand, io_operand, bit_select, offset, next_is_long, issue} =
			{r[7:0], i[7:0], b[2:0], k[6:0], l[0], 1'h1};
		e = e + dx[11:0];
		@(negedge clock);
		n = 1;
		while (done !== 1'h1 && n < 5) begin
			issue = busy;
			@(negedge clock);
			n++;
		end
		issue = 0;
		chk("pc", e, pc);
		chk("cycles", c[11:0], n[11:0]);
		if (done !== 1'h1) begin
			mismatches++;
			close_out;
		end
	endtask
	task t_compare;
		immediate = 8'h20;
		run(1, 16, 0, 0, 0, 0, 1, 1);
		chk("flags", 12'h015, {4'h0, status_flags});
		immediate = 8'h01;
		run(1, 128, 0, 0, 0, 0, 1, 1);
		chk("flags", 12'h038, {4'h0, status_flags});
		immediate = 8'h33;
		run(1, 51, 0, 0, 0, 0, 1, 1);
		chk("flags", 12'h002, {4'h0, status_flags});
	endtask
	task t_skip;
		run(2, 251, 0, 2, 0, 0, 2, 2);
		run(2, 4, 0, 2, 0, 0, 1, 1);
		run(3, 0, 128, 7, 0, 1, 3, 3);
		run(2, 251, 0, 2, 0, 1, 3, 3);
		run(3, 0, 128, 7, 0, 0, 2, 2);
		run(3, 0, 127, 7, 0, 0, 1, 1);
	endtask
	task t_branch;
		run(4, 0, 0, 1, -2, 0, -1, 2);
		run(4, 0, 0, 0, 5, 0, 1, 1);
		run(5, 0, 0, 0, 5, 0, 6, 2);
		run(5, 0, 0, 1, 5, 0, 1, 1);
		run(6, 0, 0, 0, 63, 0, 1, 1);
		chk("flags", 12'h002, {4'h0, status_flags});
		immediate = 8'h20;
		run(1, 16, 0, 0, 0, 0, 1, 1);
		run(6, 0, 0, 0, -64, 0, -63, 2);
		run(0, 0, 0, 0, 0, 0, 1, 1);
	endtask
	task t_reset;
		@(negedge clock);
		resetn = 0;
		@(negedge clock);
		chk("pc", 12'h000, pc);
		chk("flags", 12'h000, {4'h0, status_flags});
		chk("busy", 12'h000, {11'h000, busy});
		chk("done", 12'h000, {11'h000, done});
		resetn = 1;
		e = 12'h000;
		run(4, 0, 0, 1, 3, 0, 1, 1);
	endtask
	initial begin
		repeat (2) @(negedge clock);
		resetn = 1;
		chk("pc", 12'h000, pc);
		t_compare;
		t_skip;
		t_branch;
		t_reset;
		close_out;
	end
endmodule // csbu_unit_tb
